// *** pdma_pkg.sv ***
// Purpose: shared constants for the eight-channel peripheral dma block
// Assumes: 16-bit channel registers held in the low half of 32-bit bus words
// Notes:   register map, control field positions, engine states
package pdma_pkg;
   localparam int NCH  = 8;
   localparam int NREQ = 128;
   localparam int AW   = 9;
   localparam int CW   = 10;

   // channel window: channel number in addr[7:5], register index in addr[4:2]
   localparam int CH_LSB   = 5;
   localparam int IDX_LSB  = 2;
   localparam logic [AW-1:0] OFF_SHARED_A = 9'h100;
   localparam logic [AW-1:0] OFF_SHARED_B = 9'h104;

   localparam logic [2:0] RI_CON = 3'h0;
   localparam logic [2:0] RI_REQ = 3'h1;
   localparam logic [2:0] RI_STA = 3'h2;
   localparam logic [2:0] RI_STB = 3'h3;
   localparam logic [2:0] RI_PAD = 3'h4;
   localparam logic [2:0] RI_CNT = 3'h5;

   // channel_control fields; B_FORCE is the force bit of the request-select register
   localparam int B_CHANNEL_ON_BIT   = 15;
   localparam int B_SIZE   = 14;
   localparam int B_DIR    = 13;
   localparam int B_HALF   = 12;
   localparam int B_NULL_WRITE_SELECT  = 11;
   localparam int AM_LSB   = 4;
   localparam int B_ONESHOT = 0;
   localparam int B_PP     = 1;
   localparam int B_FORCE  = 15;

   localparam logic [15:0] CON_MASK = 16'hf833;
   localparam logic [15:0] REQ_MASK = 16'h807f;
   localparam logic [15:0] CNT_MASK = 16'h03ff;
   localparam logic [15:0] ALL_MASK = 16'hffff;
   localparam logic [15:0] RST_REG  = 16'h0000;

   localparam logic [1:0] AM_INC   = 2'h0;
   localparam logic [1:0] AM_NOINC = 2'h1;
   localparam logic [1:0] AM_PIA   = 2'h2;

   localparam logic [1:0] RESP_OK  = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RD   = 2'b01,
      ST_CAP  = 2'b11,
      ST_WR   = 2'b10
   } pdma_state_t;

   // byte-lane merge of a software write, unimplemented bits forced to zero
   function automatic logic [15:0] merge(input logic [15:0] old_v,
                                         input logic [15:0] new_v,
                                         input logic [1:0]  strb,
                                         input logic [15:0] mask);
      logic [15:0] r;
      r = old_v;
      if (strb[0]) r[7:0]  = new_v[7:0];
      if (strb[1]) r[15:8] = new_v[15:8];
      return r & mask;
   endfunction : merge
endpackage : pdma_pkg

// *** pdma_arb.sv ***
// Purpose: fixed-priority pick of the next ready channel
// Assumes: lower channel number wins
// Notes:   purely combinational
`timescale 1ns/1ps
module pdma_arb #(
   parameter int NCH = pdma_pkg::NCH
) (
   input  wire logic [NCH-1:0]         req,
   output logic                        any,
   output logic [$clog2(NCH)-1:0]      gnt
);
   import pdma_pkg::*;
   always_comb begin
      any = 1'b0;
      gnt = '0;
      for (int i = NCH - 1; i >= 0; i--) begin
         if (req[i]) begin
            any = 1'b1;
            gnt = ($clog2(NCH))'(i);
         end
      end
   end
endmodule : pdma_arb

// *** pdma_chan.sv ***
// Purpose: one dma channel: its registers, trigger capture and block progress
// Assumes: per_req lines are one-cycle pulses from logic on aclk
// Notes:   software writes win over hardware clears in the same cycle
`timescale 1ns/1ps
module pdma_chan #(
   parameter int NREQ = pdma_pkg::NREQ
) (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic             wr_en,
   input  wire logic [2:0]       wr_idx,
   input  wire logic [15:0]      wr_data,
   input  wire logic [1:0]       wr_strb,
   input  wire logic [NREQ-1:0]  per_req,
   input  wire logic             xfer_done,
   output logic [15:0]           con_q,
   output logic [15:0]           reqsel_q,
   output logic [15:0]           sta_q,
   output logic [15:0]           stb_q,
   output logic [15:0]           pad_q,
   output logic [15:0]           cnt_q,
   output logic [9:0]            idx_q,
   output logic                  buf_b_q,
   output logic                  rdy,
   output logic                  irq_q
);
   import pdma_pkg::*;
   logic        channel_on_bit;
   logic        hit;
   logic        last;
   logic        pend_q;
   logic        stop;
   logic [10:0] moved;
   logic [10:0] half_pt;

   assign channel_on_bit    = con_q[B_CHANNEL_ON_BIT];
   assign hit     = per_req[reqsel_q[6:0]];
   assign last    = (idx_q == cnt_q[9:0]);
   assign moved   = {1'b0, idx_q} + 11'h001;
   assign half_pt = 11'(({1'b0, cnt_q[9:0]} + 11'h002) >> 1);
   assign stop    = xfer_done & last & con_q[B_ONESHOT] & (~con_q[B_PP] | buf_b_q);
   assign rdy     = channel_on_bit & (pend_q | reqsel_q[B_FORCE]);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         con_q    <= RST_REG;
         reqsel_q <= RST_REG;
         sta_q    <= RST_REG;
         stb_q    <= RST_REG;
         pad_q    <= RST_REG;
         cnt_q    <= RST_REG;
      end else begin
         if (stop)
            con_q[B_CHANNEL_ON_BIT] <= 1'b0;
         if (xfer_done)
            reqsel_q[B_FORCE] <= 1'b0;
         if (wr_en) begin
            case (wr_idx)
               RI_CON: con_q <= merge(con_q, wr_data, wr_strb, CON_MASK);
               RI_REQ: reqsel_q <= merge(reqsel_q, wr_data, wr_strb, REQ_MASK) |
                                   {reqsel_q[B_FORCE] & ~xfer_done, 15'h0000};
               RI_STA: sta_q <= merge(sta_q, wr_data, wr_strb, ALL_MASK);
               RI_STB: stb_q <= merge(stb_q, wr_data, wr_strb, ALL_MASK);
               RI_PAD: pad_q <= merge(pad_q, wr_data, wr_strb, ALL_MASK);
               RI_CNT: cnt_q <= merge(cnt_q, wr_data, wr_strb, CNT_MASK);
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || !channel_on_bit) begin
         idx_q   <= 10'h000;
         buf_b_q <= 1'b0;
      end else if (xfer_done) begin
         if (last) begin
            idx_q <= 10'h000;
            if (con_q[B_PP])
               buf_b_q <= ~buf_b_q;
         end else begin
            idx_q <= idx_q + 10'h001;
         end
      end
   end

   // a request in the cycle its transfer ends is kept
   always_ff @(posedge aclk) begin
      if (!aresetn)
         pend_q <= 1'b0;
      else
         pend_q <= channel_on_bit & (hit | (pend_q & ~xfer_done));
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         irq_q <= 1'b0;
      else
         irq_q <= xfer_done & (con_q[B_HALF] ? (moved == half_pt) : last);
   end
endmodule : pdma_chan

// *** pdma_top.sv ***
// Purpose: eight-channel peripheral dma with an axi4-lite register slave
// Assumes: ram and peripheral ports return read data one cycle after re
// Notes:   one transfer in flight at a time across all channels
// Operation
// - eight independent channels, each own registers
// - direction bit picks ram-to-peripheral or reverse
// - size bit one byte, zero word
// - transfers use a dedicated bus
// - interrupt at block end or half
// - half bit selects interrupt point
// - addressing field picks ram address mode
// - peripheral-indirect address from requesting peripheral
// - one-shot stops after the block
// - continuous reloads start address, keeps running
// - ping-pong alternates primary and secondary buffers
// - start by peripheral request or software
// - trigger chosen from peripheral request numbers
// - ten-bit count, sixteen-bit other registers
// - two shared status registers for all
// - force does one transfer, hardware clears
// - seven-bit field selects request number
//
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
module pdma_top #(
   parameter int NCH  = pdma_pkg::NCH,
   parameter int NREQ = pdma_pkg::NREQ
) (
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   input  wire logic [pdma_pkg::AW-1:0] s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [pdma_pkg::AW-1:0] s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   input  wire logic [NREQ-1:0]      per_req,
   input  wire logic [15:0]          per_ind_addr,
   output logic [15:0]               per_addr,
   output logic                      per_re,
   output logic                      per_we,
   output logic [15:0]               per_wdata,
   output logic                      per_byte,
   input  wire logic [15:0]          per_rdata,
   output logic [15:0]               ram_addr,
   output logic                      ram_re,
   output logic                      ram_we,
   output logic [15:0]               ram_wdata,
   output logic                      ram_byte,
   input  wire logic [15:0]          ram_rdata,
   output logic [NCH-1:0]            dma_irq
);
   import pdma_pkg::*;
   localparam int CHW = $clog2(NCH);

   // register decode: {mapped, shared, shared_b, channel, index}
   function automatic logic [8:0] decode(input logic [AW-1:0] a);
      logic [8:0] r;
      r = '0;
      if (a[AW-1:2] == OFF_SHARED_A[AW-1:2])
         r = {1'b1, 1'b1, 1'b0, 6'h00};
      else if (a[AW-1:2] == OFF_SHARED_B[AW-1:2])
         r = {1'b1, 1'b1, 1'b1, 6'h00};
      else if (!a[AW-1] && a[4:2] <= RI_CNT)
         r = {1'b1, 1'b0, 1'b0, a[7:5], a[4:2]};
      return r;
   endfunction : decode

   logic [NCH-1:0][15:0] con;
   logic [NCH-1:0][15:0] reqsel;
   logic [NCH-1:0][15:0] sta;
   logic [NCH-1:0][15:0] stb;
   logic [NCH-1:0][15:0] pad;
   logic [NCH-1:0][15:0] cnt;
   logic [NCH-1:0][9:0]  idx;
   logic [NCH-1:0]       buf_b;
   logic [NCH-1:0]       rdy;
   logic [NCH-1:0]       xfer_done;
   logic                 any;
   logic [CHW-1:0]       gnt;

   // axi write side
   logic                 aw_full_q;
   logic                 w_full_q;
   logic [AW-1:0]        aw_addr_q;
   logic [15:0]          w_data_q;
   logic [1:0]           w_strb_q;
   logic                 aw_full_d;
   logic                 w_full_d;
   logic                 do_wr;
   logic [8:0]           wdec;
   // axi read side
   logic                 ar_full_q;
   logic [AW-1:0]        ar_addr_q;
   logic                 ar_full_d;
   logic                 do_rd;
   logic [8:0]           rdec;
   logic [15:0]          rd_val;

   // engine
   pdma_state_t          state_q;
   logic [CHW-1:0]       cur_q;
   logic [CHW-1:0]       last_ch_q;
   logic                 dir_q;
   logic                 size_q;
   logic                 null_write_select_q;
   logic [15:0]          ram_a;
   logic [15:0]          base;
   logic [15:0]          cap;

   assign do_wr     = aw_full_q & w_full_q & ~s_axi_bvalid;
   assign aw_full_d = do_wr ? 1'b0 : (aw_full_q | (s_axi_awvalid & s_axi_awready));
   assign w_full_d  = do_wr ? 1'b0 : (w_full_q | (s_axi_wvalid & s_axi_wready));
   assign wdec      = decode(aw_addr_q);
   assign do_rd     = ar_full_q & ~s_axi_rvalid;
   assign ar_full_d = do_rd ? 1'b0 : (ar_full_q | (s_axi_arvalid & s_axi_arready));
   assign rdec      = decode(ar_addr_q);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q     <= 1'b0;
         w_full_q      <= 1'b0;
         aw_addr_q     <= '0;
         w_data_q      <= 16'h0000;
         w_strb_q      <= 2'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OK;
      end else begin
         aw_full_q     <= aw_full_d;
         w_full_q      <= w_full_d;
         s_axi_awready <= ~aw_full_d;
         s_axi_wready  <= ~w_full_d;
         if (s_axi_awvalid && s_axi_awready)
            aw_addr_q <= s_axi_awaddr;
         if (s_axi_wvalid && s_axi_wready) begin
            w_data_q <= s_axi_wdata[15:0];
            w_strb_q <= s_axi_wstrb[1:0];
         end
         if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            // shared status is read-only, so writes there are refused
            s_axi_bresp  <= (wdec[8] && !wdec[7]) ? RESP_OK : RESP_ERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_comb begin
      rd_val = 16'h0000;
      if (rdec[7]) begin
         if (rdec[6])
            rd_val = {5'h00, 3'(last_ch_q), 8'(rdy)};
         else
            rd_val = {8'h00, 8'(buf_b)};
      end else begin
         case (rdec[2:0])
            RI_CON:  rd_val = con[rdec[3+:CHW]];
            RI_REQ:  rd_val = reqsel[rdec[3+:CHW]];
            RI_STA:  rd_val = sta[rdec[3+:CHW]];
            RI_STB:  rd_val = stb[rdec[3+:CHW]];
            RI_PAD:  rd_val = pad[rdec[3+:CHW]];
            RI_CNT:  rd_val = cnt[rdec[3+:CHW]];
            default: rd_val = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ar_full_q     <= 1'b0;
         ar_addr_q     <= '0;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OK;
      end else begin
         ar_full_q     <= ar_full_d;
         s_axi_arready <= ~ar_full_d;
         if (s_axi_arvalid && s_axi_arready)
            ar_addr_q <= s_axi_araddr;
         if (do_rd) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {16'h0000, rdec[8] ? rd_val : 16'h0000};
            s_axi_rresp  <= rdec[8] ? RESP_OK : RESP_ERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   for (genvar g = 0; g < NCH; g++) begin : g_ch
      pdma_chan #(.NREQ(NREQ)) u_chan (
         .aclk      (aclk),
         .aresetn   (aresetn),
         .wr_en     (do_wr && wdec[8] && !wdec[7] && wdec[3+:CHW] == CHW'(g)),
         .wr_idx    (wdec[2:0]),
         .wr_data   (w_data_q),
         .wr_strb   (w_strb_q),
         .per_req   (per_req),
         .xfer_done (xfer_done[g]),
         .con_q     (con[g]),
         .reqsel_q  (reqsel[g]),
         .sta_q     (sta[g]),
         .stb_q     (stb[g]),
         .pad_q     (pad[g]),
         .cnt_q     (cnt[g]),
         .idx_q     (idx[g]),
         .buf_b_q   (buf_b[g]),
         .rdy       (rdy[g]),
         .irq_q     (dma_irq[g])
      );
      assign xfer_done[g] = (state_q == ST_WR) && (cur_q == CHW'(g));
   end

   pdma_arb #(.NCH(NCH)) u_arb (
      .req (rdy),
      .any (any),
      .gnt (gnt)
   );

   assign base = buf_b[gnt] ? stb[gnt] : sta[gnt];

   always_comb begin
      case (con[gnt][AM_LSB+:2])
         AM_INC:  ram_a = base + (con[gnt][B_SIZE] ? 16'(idx[gnt]) : {5'h00, idx[gnt], 1'b0});
         AM_PIA:  ram_a = base + per_ind_addr;
         default: ram_a = base;
      endcase
   end

   assign cap = size_q ? {8'h00, (dir_q ? ram_rdata[7:0] : per_rdata[7:0])}
                       : (dir_q ? ram_rdata : per_rdata);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q   <= ST_IDLE;
         cur_q     <= '0;
         last_ch_q <= '0;
         dir_q     <= 1'b0;
         size_q    <= 1'b0;
         null_write_select_q   <= 1'b0;
         ram_addr  <= 16'h0000;
         per_addr  <= 16'h0000;
         ram_re    <= 1'b0;
         per_re    <= 1'b0;
         ram_we    <= 1'b0;
         per_we    <= 1'b0;
         ram_wdata <= 16'h0000;
         per_wdata <= 16'h0000;
         ram_byte  <= 1'b0;
         per_byte  <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (any) begin
                  cur_q    <= gnt;
                  dir_q    <= con[gnt][B_DIR];
                  size_q   <= con[gnt][B_SIZE];
                  null_write_select_q  <= con[gnt][B_NULL_WRITE_SELECT];
                  ram_addr <= ram_a;
                  per_addr <= pad[gnt];
                  ram_byte <= con[gnt][B_SIZE];
                  per_byte <= con[gnt][B_SIZE];
                  ram_re   <= con[gnt][B_DIR];
                  per_re   <= ~con[gnt][B_DIR];
                  state_q  <= ST_RD;
               end
            end
            ST_RD: begin
               ram_re  <= 1'b0;
               per_re  <= 1'b0;
               state_q <= ST_CAP;
            end
            ST_CAP: begin
               ram_wdata <= cap;
               per_wdata <= dir_q ? cap : 16'h0000;
               ram_we    <= ~dir_q;
               per_we    <= dir_q | null_write_select_q;
               state_q   <= ST_WR;
            end
            ST_WR: begin
               ram_we    <= 1'b0;
               per_we    <= 1'b0;
               last_ch_q <= cur_q;
               state_q   <= ST_IDLE;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end
endmodule : pdma_top

// *** pdma_assertions.sv ***
// Purpose: port-level checks for the peripheral dma top
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to pdma_top at the foot of this file
`timescale 1ns/1ps
module pdma_assertions #(
   parameter int NCH = 8
) (
   input wire logic           aclk,
   input wire logic           aresetn,
   input wire logic           s_axi_bvalid,
   input wire logic           s_axi_bready,
   input wire logic [1:0]     s_axi_bresp,
   input wire logic           s_axi_rvalid,
   input wire logic           s_axi_rready,
   input wire logic [31:0]    s_axi_rdata,
   input wire logic           per_re,
   input wire logic           per_we,
   input wire logic [15:0]    per_wdata,
   input wire logic           ram_re,
   input wire logic           ram_we,
   input wire logic [NCH-1:0] dma_irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   bresp_hold_a: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   rdata_hold_a: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   rdata_upper_a: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
      else $error("upper read half not zero");
   read_pulse_a: assert property (
      per_re || ram_re |=> !per_re && !ram_re)
      else $error("read strobe longer than one cycle");
   per_to_ram_a: assert property (
      per_re |-> ##2 ram_we)
      else $error("peripheral read not followed by ram write");
   ram_to_per_a: assert property (
      ram_re |-> ##2 per_we)
      else $error("ram read not followed by peripheral write");
   irq_pulse_a: assert property (
      |dma_irq |=> dma_irq == '0)
      else $error("interrupt longer than one cycle");
   irq_cause_a: assert property (
      |dma_irq |-> $past(ram_we || per_we))
      else $error("interrupt without a preceding write");
   null_zero_a: assert property (
      per_we && ram_we |-> per_wdata == 16'h0000)
      else $error("null write carried data");
endmodule : pdma_assertions

bind pdma_top pdma_assertions #(.NCH(NCH)) i_chk (
   .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .per_re(per_re),
   .per_we(per_we), .per_wdata(per_wdata), .ram_re(ram_re), .ram_we(ram_we),
   .dma_irq(dma_irq)
);

// *** pdma_mem_model.sv ***
// Purpose: peripheral registers and dma ram on the far side
// Assumes: read data valid the cycle after the read strobe
// Notes:   outside that cycle the data lines show the inverse, never a stale copy
`timescale 1ns/1ps
module pdma_mem_model (
   input  wire logic        aclk,
   input  wire logic [15:0] per_addr,
   input  wire logic        per_re,
   input  wire logic        per_we,
   input  wire logic [15:0] per_wdata,
   input  wire logic        per_byte,
   output logic      [15:0] per_rdata,
   input  wire logic [15:0] ram_addr,
   input  wire logic        ram_re,
   input  wire logic        ram_we,
   input  wire logic [15:0] ram_wdata,
   input  wire logic        ram_byte,
   output logic      [15:0] ram_rdata
);
   logic [15:0] per_mem [16];
   logic [15:0] ram_mem [256];
   logic [15:0] per_q, ram_q;
   logic        per_v, ram_v;

   function automatic logic [15:0] rd(input logic [15:0] m, input logic b, input logic a);
      return !b ? m : {8'h00, a ? m[15:8] : m[7:0]};
   endfunction : rd

   function automatic logic [15:0] wr(input logic [15:0] m, input logic [15:0] d,
                                      input logic b, input logic a);
      return !b ? d : (a ? {d[7:0], m[7:0]} : {m[15:8], d[7:0]});
   endfunction : wr

   initial begin
      per_q = 16'h0000;
      ram_q = 16'h0000;
      foreach (per_mem[i]) per_mem[i] = 16'h0000;
      foreach (ram_mem[i]) ram_mem[i] = 16'h0000;
   end

   always @(posedge aclk) begin
      per_v <= per_re;
      ram_v <= ram_re;
      if (per_re) per_q <= rd(per_mem[per_addr[4:1]], per_byte, per_addr[0]);
      if (ram_re) ram_q <= rd(ram_mem[ram_addr[8:1]], ram_byte, ram_addr[0]);
      if (per_we) per_mem[per_addr[4:1]] <= wr(per_mem[per_addr[4:1]], per_wdata, per_byte,
                                               per_addr[0]);
      if (ram_we) ram_mem[ram_addr[8:1]] <= wr(ram_mem[ram_addr[8:1]], ram_wdata, ram_byte,
                                               ram_addr[0]);
   end

   assign per_rdata = per_v ? per_q : ~per_q;
   assign ram_rdata = ram_v ? ram_q : ~ram_q;
endmodule : pdma_mem_model

// *** pdma_top_tb.sv ***
// Purpose: register and transfer scenarios for the peripheral dma
// Assumes: partner model answers one cycle after each strobe
// Notes:   channel n registers at n*0x20; waits after requests cover one transfer
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
   $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module pdma_top_tb;
   import pdma_pkg::*;
   logic          aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic          s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic          s_axi_rvalid, s_axi_rready, per_re, per_we, per_byte, ram_re, ram_we, ram_byte;
   logic [AW-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0]   s_axi_wdata, s_axi_rdata;
   logic [3:0]    s_axi_wstrb;
   logic [1:0]    s_axi_bresp, s_axi_rresp;
   logic [127:0]  per_req;
   logic [15:0]   per_ind_addr, per_addr, per_wdata, per_rdata, ram_addr, ram_wdata, ram_rdata;
   logic [7:0]    dma_irq;
   int            num_errors, checks, wr_n;
   int            irq_n [8];

   pdma_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .per_req, .per_ind_addr, .per_addr,
      .per_re, .per_we, .per_wdata, .per_byte, .per_rdata, .ram_addr, .ram_re, .ram_we,
      .ram_wdata, .ram_byte, .ram_rdata, .dma_irq);
   pdma_mem_model i_mem (.aclk, .per_addr, .per_re, .per_we, .per_wdata, .per_byte,
      .per_rdata, .ram_addr, .ram_re, .ram_we, .ram_wdata, .ram_byte, .ram_rdata);

   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   always @(posedge aclk) begin
      if (ram_we || per_we) wr_n++;
      for (int i = 0; i < 8; i++) if (dma_irq[i]) irq_n[i]++;
   end

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : complete_run

   task automatic cyc(input int k);
      repeat (k) @(posedge aclk);
   endtask : cyc

   // one register access; valids drop only after the edge that took them
   task automatic acc(input logic w, input logic [8:0] a, input logic [15:0] d,
                      input logic [1:0] er);
      int          n;
      logic        aw_h, w_h, ar_h, fin;
      logic [31:0] rd;
      logic [1:0]  rs;
      fin = 1'b0;
      n = 0;
      @(posedge aclk);
      if (w) begin
         s_axi_awaddr <= a;
         s_axi_awvalid <= 1'b1;
         s_axi_wdata <= {16'h0000, d};
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
      end else begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
      end
      while (!fin && n < 100) begin
         @(negedge aclk);
         n++;
         aw_h = s_axi_awvalid && s_axi_awready;
         w_h = s_axi_wvalid && s_axi_wready;
         ar_h = s_axi_arvalid && s_axi_arready;
         fin = w ? s_axi_bvalid : s_axi_rvalid;
         rd = s_axi_rdata;
         rs = w ? s_axi_bresp : s_axi_rresp;
         @(posedge aclk);
         if (aw_h) s_axi_awvalid <= 1'b0;
         if (w_h) s_axi_wvalid <= 1'b0;
         if (ar_h) s_axi_arvalid <= 1'b0;
         if (fin) begin
            s_axi_bready <= 1'b0;
            s_axi_rready <= 1'b0;
         end
      end
      if (!fin) begin
         num_errors++;
         complete_run();
      end
      `CHK(rs, er)
      if (!w) `CHK(rd, {16'h0000, d})
   endtask : acc

   task automatic pulse(input int r);
      per_req <= 128'(1) << r;
      @(posedge aclk);
      per_req <= '0;
      cyc(10);
   endtask : pulse

   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, per_req, per_ind_addr} = '0;
      s_axi_wstrb = 4'hf;
      cyc(20);
      aresetn <= 1'b1;
      cyc(1);
      i_mem.per_mem[2] = 16'h1234;
      i_mem.ram_mem[16] = 16'h00a5;
      i_mem.per_mem[4] = 16'h5a5a;
      i_mem.ram_mem[48] = 16'hffff;
      i_mem.per_mem[5] = 16'h7e7e;
      acc(1'b0, 9'h000, 16'h0000, RESP_OK);
      acc(1'b0, 9'h018, 16'h0000, RESP_ERR);
      acc(1'b1, 9'h100, 16'h00ff, RESP_ERR);
      acc(1'b0, 9'h104, 16'h0000, RESP_OK);
      $display("test reset_map done");
      acc(1'b1, 9'h060, 16'hffff, RESP_OK);
      acc(1'b0, 9'h060, 16'hf833, RESP_OK);
      acc(1'b1, 9'h060, 16'h0000, RESP_OK);
      acc(1'b1, 9'h074, 16'hffff, RESP_OK);
      acc(1'b0, 9'h074, 16'h03ff, RESP_OK);
      acc(1'b1, 9'h064, 16'h7fff, RESP_OK);
      acc(1'b0, 9'h064, 16'h007f, RESP_OK);
      acc(1'b0, 9'h040, 16'h0000, RESP_OK);
      $display("test masks done");
      acc(1'b1, 9'h044, 16'h0007, RESP_OK);
      acc(1'b1, 9'h040, 16'h0001, RESP_OK);
      pulse(7);
      `CHK(wr_n, 0)
      $display("test gating done");
      acc(1'b1, 9'h028, 16'h0010, RESP_OK);
      acc(1'b1, 9'h030, 16'h0004, RESP_OK);
      acc(1'b1, 9'h034, 16'h0002, RESP_OK);
      acc(1'b1, 9'h024, 16'h000d, RESP_OK);
      acc(1'b1, 9'h020, 16'h8001, RESP_OK);
      repeat (3) pulse(13);
      for (int i = 8; i < 11; i++) `CHK(i_mem.ram_mem[i], 16'h1234)
      `CHK(i_mem.ram_mem[11], 16'h0000)
      `CHK(irq_n[1], 1)
      acc(1'b0, 9'h020, 16'h0001, RESP_OK);
      $display("test one_shot done");
      acc(1'b1, 9'h008, 16'h0020, RESP_OK);
      acc(1'b1, 9'h010, 16'h0006, RESP_OK);
      acc(1'b1, 9'h014, 16'h0003, RESP_OK);
      acc(1'b1, 9'h000, 16'hf012, RESP_OK);
      for (int i = 0; i < 4; i++) begin
         acc(1'b1, 9'h004, 16'h8000, RESP_OK);
         cyc(10);
         acc(1'b0, 9'h004, 16'h0000, RESP_OK);
         if (i == 1) `CHK(irq_n[0], 1)
      end
      `CHK(irq_n[0], 1)
      `CHK(i_mem.per_mem[3], 16'h00a5)
      acc(1'b0, 9'h000, 16'hf012, RESP_OK);
      acc(1'b1, 9'h000, 16'h0000, RESP_OK);
      $display("test force_half done");
      acc(1'b1, 9'h088, 16'h0040, RESP_OK);
      acc(1'b1, 9'h08c, 16'h0060, RESP_OK);
      acc(1'b1, 9'h090, 16'h0008, RESP_OK);
      acc(1'b1, 9'h080, 16'h8833, RESP_OK);
      repeat (2) pulse(0);
      `CHK(i_mem.ram_mem[32], 16'h5a5a)
      `CHK(i_mem.ram_mem[48], 16'h0000)
      `CHK(i_mem.per_mem[4], 16'h0000)
      `CHK(irq_n[4], 2)
      acc(1'b0, 9'h080, 16'h0833, RESP_OK);
      $display("test ping_pong done");
      per_ind_addr <= 16'h0080;
      acc(1'b1, 9'h0b0, 16'h000a, RESP_OK);
      acc(1'b1, 9'h0a0, 16'h8020, RESP_OK);
      pulse(0);
      `CHK(i_mem.ram_mem[64], 16'h7e7e)
      acc(1'b0, 9'h0a0, 16'h8020, RESP_OK);
      $display("test indirect done");
      complete_run();
   end
endmodule : pdma_top_tb
